//--- test/csr_cam_tx.sv
// Behavioural camera transmitter that drives the five lane pairs of the receiver.
// Assumes the receiver samples the pins with its own clock; pair 0 is the clock lane.
`default_nettype none

module csr_cam_tx (
	// Lane pins.
	output logic [4:0] lane_p_o,
	output logic [4:0] lane_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] stream[$];
	initial begin
		lane_p_o = 5'h1F;
		lane_n_o = 5'h1F;
	end
	// The clock lane toggles only inside a burst and sits in the stop state between bursts.
	task automatic send(input int lanes);
		logic [7:0] b;
		int nb;
		nb = (stream.size() + lanes - 1) / lanes;
		#1;
		lane_p_o = 5'h00;
		lane_n_o = 5'h1F;
		#125;
		for (int k = -1; k < nb; k++) begin
			for (int i = 0; i < 8; i++) begin
				for (int l = 0; l < lanes; l++) begin
					b = (k < 0) ? 8'hB8 : stream[k * lanes + l];
					lane_p_o[l + 1] = b[i];
					lane_n_o[l + 1] = ~b[i];
				end
				#31;
				lane_p_o[0] = ~lane_p_o[0];
				lane_n_o[0] = ~lane_n_o[0];
				#31.5;
			end
		end
		#125;
		rest(1'b1);
		stream.delete();
	endtask
	// Both lines low is the sleep state, both high the stop state.
	task automatic rest(input logic lvl);
		#1;
		lane_p_o = {5{lvl}};
		lane_n_o = {5{lvl}};
	endtask
endmodule // csr_cam_tx

`default_nettype wire

//--- test/csr_fabric_port_test.sv
// Self-checking bench for the camera serial receiver port with a modelled transmitter.
// Assumes registered outputs on clock_i and read data one cycle after the read strobe.
`default_nettype none

module csr_fabric_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic phy_n = 1'b0;
	logic ctl_n = 1'b0;
	logic [3:0] vc_en = 4'h0;
	logic [1:0] lane_sel = 2'h0;
	logic err_clr = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wr_data_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic rd_seen = 1'b0;
	logic [4:0] lane_p, lane_n;
	logic [3:0] vsync_o, hsync_o, pixel_count_o, sleep_o;
	logic video_valid_o, clk_sleep_o, irq_o;
	logic [63:0] video_data_o;
	logic [5:0] data_type_o;
	logic [1:0] vc_o;
	logic [17:0] error_o;
	logic [31:0] reg_rd_data_o;
	logic [75:0] exp_video[$];
	logic [31:0] exp_reg[$];
	int n_mismatch = 0;
	int tests_run = 0;
	logic [1:0] codes[3] = '{2'h0, 2'h1, 2'h3};
	logic [3:0] lanes_on[3] = '{4'h1, 4'h3, 4'hF};
	logic [5:0] types[3] = '{6'h2A, 6'h1E, 6'h30};
	int widths[3] = '{1, 2, 4};

	always #5 clock_i = ~clock_i;

	csr_cam_tx tx (.lane_p_o(lane_p), .lane_n_o(lane_n));

	csr_fabric_port DUT (.clock_i(clock_i), .srst_i(srst_i), .phy_reset_n_i(phy_n),
		.controller_reset_n_i(ctl_n), .virtual_channel_enables_i(vc_en),
		.lane_select_i(lane_sel), .error_clear_i(err_clr), .lane_p_i(lane_p), .lane_n_i(lane_n),
		.vsync_o(vsync_o), .hsync_o(hsync_o), .video_valid_o(video_valid_o),
		.pixel_count_o(pixel_count_o), .video_data_o(video_data_o), .data_type_o(data_type_o),
		.virtual_channel_id_o(vc_o), .error_o(error_o), .clock_lane_sleep_flag_o(clk_sleep_o),
		.data_lane_sleep_flags_o(sleep_o), .reg_addr_i(reg_addr_i), .reg_wr_data_i(reg_wr_data_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rd_data_o(reg_rd_data_o), .irq_o(irq_o));

	task automatic note(input string what, input logic [75:0] e, input logic [75:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic chk_video(input logic [75:0] e, input logic [75:0] g);
		note("video word", e, g);
	endtask
	task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
		note("read data", 76'(e), 76'(g));
	endtask
	task automatic chk_pin(input string what, input logic [17:0] e, input logic [17:0] g);
		note(what, 76'(e), 76'(g));
	endtask
	task automatic test_done;
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Each result that shows at the outputs takes the oldest note of its kind.
	always @(posedge clock_i) begin
		rd_seen <= reg_rd_i;
		if (rd_seen) begin
			chk_reg(exp_reg.size() ? exp_reg.pop_front() : 'x, reg_rd_data_o);
		end
		if (video_valid_o) begin
			chk_video(exp_video.size() ? exp_video.pop_front() : 'x,
				{video_data_o, pixel_count_o, data_type_o, vc_o});
		end
	end

	task automatic reg_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wr_data_i <= d;
		reg_wr_i <= wr;
		reg_rd_i <= ~wr;
		if (!wr) exp_reg.push_back(d);
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
	endtask
	task automatic resets(input logic lvl);
		@(posedge clock_i);
		phy_n <= lvl;
		ctl_n <= lvl;
		repeat (8) @(posedge clock_i);
	endtask
	// Queues one packet for the transmitter; ok says whether its words must come out.
	task automatic packet(input logic [1:0] vc, input logic [5:0] dt, input int n, input bit ok);
		logic [63:0] w;
		logic [7:0] b;
		w = 64'h0;
		tx.stream.push_back({vc, dt});
		tx.stream.push_back(n[7:0]);
		tx.stream.push_back(n[15:8]);
		tx.stream.push_back(8'h00);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			tx.stream.push_back(b);
			w[8 * (i % 8) +: 8] = b;
			if (i % 8 == 7 || i == n - 1) begin
				if (ok) exp_video.push_back({w, 4'(i % 8 + 1), dt, vc});
				w = 64'h0;
			end
		end
		if (n > 0) tx.stream.push_back(8'h5A);
		if (n > 0) tx.stream.push_back(8'hA5);
	endtask
	task automatic burst(input int lanes);
		tx.send(lanes);
		for (int i = 0; i < 300 && exp_video.size() > 0; i++) @(posedge clock_i);
		if (exp_video.size() > 0) begin
			n_mismatch++;
			test_done();
		end
		repeat (12) @(posedge clock_i);
	endtask

	initial begin
		void'($urandom(32'h3D14AFCC));
		repeat (16) @(posedge clock_i);
		srst_i <= 1'b0;
		reg_access(1'b0, csr_pkg::REG_MASK, 32'h0);
		reg_access(1'b1, 4'h2, 32'hFFFFFFFF);
		reg_access(1'b0, 4'h2, 32'h0);
		for (int k = 0; k < 3; k++) begin
			resets(1'b0);
			lane_sel <= codes[k];
			resets(1'b1);
			reg_access(1'b0, csr_pkg::REG_LANE_STATE, {20'h0, lanes_on[k], 8'h0});
			vc_en <= 4'h1 | 4'($urandom);
			packet(2'h0, csr_pkg::DT_FRAME_START, 0, 1'b1);
			packet(2'h0, csr_pkg::DT_LINE_START, 0, 1'b1);
			packet(2'h0, types[k], 14, 1'b1);
			burst(widths[k]);
			chk_pin("sync", 18'h11, 18'({vsync_o, hsync_o}));
		end
		packet(2'h0, csr_pkg::DT_FRAME_END, 0, 1'b1);
		burst(4);
		chk_pin("sync", 18'h0, 18'({vsync_o, hsync_o}));
		reg_access(1'b0, csr_pkg::REG_STATUS, 32'h3);
		reg_access(1'b1, csr_pkg::REG_MASK, 32'h8);
		vc_en <= 4'h1;
		packet(2'h1, 6'h2A, 10, 1'b0);
		burst(4);
		chk_pin("irq", 18'h1, 18'(irq_o));
		chk_pin("error", 18'h1000, error_o);
		reg_access(1'b0, csr_pkg::REG_STATUS, 32'hC);
		reg_access(1'b0, csr_pkg::REG_ERROR, 32'h1000);
		err_clr <= 1'b1;
		repeat (2) @(posedge clock_i);
		err_clr <= 1'b0;
		chk_pin("irq", 18'h0, 18'(irq_o));
		chk_pin("error", 18'h0, error_o);
		packet(2'h0, 6'h1B, 10, 1'b0);
		burst(4);
		chk_pin("error", 18'h2000, error_o);
		resets(1'b0);
		packet(2'h0, csr_pkg::DT_FRAME_START, 0, 1'b0);
		packet(2'h0, 6'h2A, 10, 1'b0);
		burst(4);
		chk_pin("vsync", 18'h0, 18'(vsync_o));
		resets(1'b1);
		tx.rest(1'b0);
		for (int i = 0; i < 40 && clk_sleep_o !== 1'b1; i++) @(posedge clock_i);
		if (clk_sleep_o !== 1'b1) begin
			n_mismatch++;
			test_done();
		end
		repeat (4) @(posedge clock_i);
		chk_pin("sleep", 18'h1F, 18'({sleep_o, clk_sleep_o}));
		tx.rest(1'b1);
		repeat (20) @(posedge clock_i);
		chk_pin("sleep", 18'h0, 18'({sleep_o, clk_sleep_o}));
		test_done();
	end
endmodule // csr_fabric_port_test

`default_nettype wire

//--- verilog/csr_fabric_port.sv
// Receive side of a camera serial link as seen by the fabric: lanes in, video and status out.
// Assumes clock_i is the pixel clock and that lane pins and the two resets are asynchronous.
// Function
// - Five differential lane inputs reach the board: one link clock lane and four data.
// - A low physical-layer reset holds the lane logic in reset; high releases it.
// - A low controller reset holds the packet controller in reset; high releases it.
// - Traffic of a virtual channel is accepted only while its enable bit is high.
// - Lane select 00 enables lane 0, 01 lanes 0 and 1, and 11 all four lanes.
// - All transfers into the core are timed by the fabric pixel clock.
// - Decoded video payload leaves on the video output group.
// - An optional status group reports operating state and errors.
// - Each pixel clock presents syncs, valid, pixel count, 64-bit data, type and channel.
// - Errors stay in an 18-bit register until the clear input resets them.
// - Sleep flags are high while the clock lane or a data lane is in ultra-low power.
//
// Chosen here: the register addresses and the address-and-strobe port.
`default_nettype none

module csr_fabric_port (
	// Pixel clock and reset.
	input wire logic clock_i,
	input wire logic srst_i,
	// Fabric control.
	input wire logic phy_reset_n_i,
	input wire logic controller_reset_n_i,
	input wire logic [3:0] virtual_channel_enables_i,
	input wire logic [1:0] lane_select_i,
	input wire logic error_clear_i,
	// Lane pins, index 0 is the clock lane.
	input wire logic [4:0] lane_p_i,
	input wire logic [4:0] lane_n_i,
	// Video output group.
	output logic [3:0] vsync_o,
	output logic [3:0] hsync_o,
	output logic video_valid_o,
	output logic [3:0] pixel_count_o,
	output logic [63:0] video_data_o,
	output logic [5:0] data_type_o,
	output logic [1:0] virtual_channel_id_o,
	// Status output group.
	output logic [17:0] error_o,
	output logic clock_lane_sleep_flag_o,
	output logic [3:0] data_lane_sleep_flags_o,
	// Register port and interrupt.
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wr_data_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rd_data_o,
	output logic irq_o
);

	logic [11:0] pin_sync;
	logic [4:0] lane_p_s;
	logic [4:0] lane_n_s;
	logic phy_run;
	logic ctrl_run;
	logic clk_hs;
	logic clk_level_reg;
	logic link_edge;
	logic [1:0] lane_sel_reg;
	logic [3:0] lane_en;
	logic [7:0] lane_byte [4];
	logic [3:0] lane_stb;
	logic [3:0] lane_lock;
	logic [3:0] lane_sot_err;
	logic lock_q_reg;
	logic burst_end;
	logic [31:0] grp_reg;
	logic [2:0] grp_left_reg;
	logic grp_load;
	logic byte_take;
	logic [7:0] cur_byte;
	csr_pkg::csr_parse_e state_reg;
	logic [1:0] hdr_vc_reg;
	logic [5:0] hdr_dt_reg;
	logic [15:0] wc_reg;
	logic keep_reg;
	logic [63:0] word_reg;
	logic [63:0] word_merged;
	logic [2:0] byte_idx_reg;
	logic hdr_done;
	logic is_short;
	logic vc_ok;
	logic pay_take;
	logic flush;
	logic [3:0] vsync_next;
	logic [3:0] hsync_next;
	logic [17:0] err_set;
	logic [3:0] ev_set;
	logic [3:0] status_reg;
	logic [3:0] status_next;
	logic [3:0] mask_reg;

	// Pins and resets pass two flip-flops; a held reset reads as low afterwards too.
	csr_sync #(.W(12)) u_pin_sync (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.async_i({controller_reset_n_i, phy_reset_n_i, lane_n_i, lane_p_i}),
		.sync_o(pin_sync)
	);

	assign lane_p_s = pin_sync[4:0];
	assign lane_n_s = pin_sync[9:5];
	assign phy_run = !srst_i && pin_sync[10];
	assign ctrl_run = !srst_i && pin_sync[11];

	// A lane is in high speed while its pair differs; the clock lane gives both edges.
	assign clk_hs = lane_p_s[0] != lane_n_s[0];
	assign link_edge = clk_hs && lane_p_s[0] != clk_level_reg;

	always_ff @(posedge clock_i) begin
		if (!phy_run) begin
			clk_level_reg <= 1'b0;
		end else begin
			clk_level_reg <= lane_p_s[0];
		end
	end

	// The lane count is taken only while the controller is held in reset.
	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			lane_sel_reg <= lane_select_i;
		end
	end

	assign lane_en = csr_pkg::lanes_decode(lane_sel_reg);

	for (genvar g = 0; g < csr_pkg::LANE_COUNT; g++) begin : g_lane
		csr_lane_deser u_lane (
			.clock_i(clock_i),
			.srst_i(!phy_run || !lane_en[g]),
			.hs_i(clk_hs && lane_p_s[g+1] != lane_n_s[g+1]),
			.bit_stb_i(link_edge),
			.bit_i(lane_p_s[g+1]),
			.byte_o(lane_byte[g]),
			.byte_stb_o(lane_stb[g]),
			.locked_o(lane_lock[g]),
			.sot_err_o(lane_sot_err[g])
		);
	end

	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			lock_q_reg <= 1'b0;
		end else begin
			lock_q_reg <= lane_lock[0];
		end
	end

	assign burst_end = lock_q_reg && !lane_lock[0];

	// Bytes of one lane group are handed to the parser one per cycle, lane 0 first.
	assign grp_load = lane_stb[0] && ctrl_run;
	assign byte_take = grp_left_reg != 3'h0;
	assign cur_byte = grp_reg[7:0];

	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			grp_reg <= 32'h0000_0000;
			grp_left_reg <= 3'h0;
		end else if (grp_load) begin
			grp_reg <= {lane_byte[3], lane_byte[2], lane_byte[1], lane_byte[0]};
			grp_left_reg <= csr_pkg::lane_total(lane_sel_reg);
		end else if (byte_take) begin
			grp_reg <= {8'h00, grp_reg[31:8]};
			grp_left_reg <= grp_left_reg - 3'h1;
		end
	end

	assign hdr_done = byte_take && state_reg == csr_pkg::ST_ECC;
	assign is_short = hdr_dt_reg < csr_pkg::DT_SHORT_LIMIT;
	assign vc_ok = virtual_channel_enables_i[hdr_vc_reg];
	assign pay_take = byte_take && state_reg == csr_pkg::ST_PAYLOAD;
	assign flush = pay_take && keep_reg && vc_ok && (byte_idx_reg == 3'h7 || wc_reg == 16'h0001);

	// Packet parser: header, word count, check byte, payload, two trailer bytes.
	always_ff @(posedge clock_i) begin
		if (!ctrl_run || burst_end) begin
			state_reg <= csr_pkg::ST_HEADER;
		end else if (byte_take) begin
			case (state_reg)
				csr_pkg::ST_HEADER: state_reg <= csr_pkg::ST_WC_LO;
				csr_pkg::ST_WC_LO: state_reg <= csr_pkg::ST_WC_HI;
				csr_pkg::ST_WC_HI: state_reg <= csr_pkg::ST_ECC;
				csr_pkg::ST_ECC: begin
					if (is_short) begin
						state_reg <= csr_pkg::ST_HEADER;
					end else if (wc_reg == 16'h0000) begin
						state_reg <= csr_pkg::ST_CRC0;
					end else begin
						state_reg <= csr_pkg::ST_PAYLOAD;
					end
				end
				csr_pkg::ST_PAYLOAD: begin
					if (wc_reg == 16'h0001) begin
						state_reg <= csr_pkg::ST_CRC0;
					end
				end
				csr_pkg::ST_CRC0: state_reg <= csr_pkg::ST_CRC1;
				default: state_reg <= csr_pkg::ST_HEADER;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			hdr_vc_reg <= 2'h0;
			hdr_dt_reg <= 6'h00;
			wc_reg <= 16'h0000;
			keep_reg <= 1'b0;
		end else if (byte_take) begin
			case (state_reg)
				csr_pkg::ST_HEADER: begin
					hdr_vc_reg <= cur_byte[7:6];
					hdr_dt_reg <= cur_byte[5:0];
				end
				csr_pkg::ST_WC_LO: wc_reg[7:0] <= cur_byte;
				csr_pkg::ST_WC_HI: wc_reg[15:8] <= cur_byte;
				csr_pkg::ST_ECC: keep_reg <= vc_ok && csr_pkg::dt_known(hdr_dt_reg);
				csr_pkg::ST_PAYLOAD: wc_reg <= wc_reg - 16'h0001;
				default: keep_reg <= keep_reg;
			endcase
		end
	end

	// Payload bytes fill the word low byte first; a short final word has zero upper bytes.
	always_comb begin
		word_merged = word_reg;
		word_merged[byte_idx_reg*8 +: 8] = cur_byte;
	end

	always_ff @(posedge clock_i) begin
		if (!ctrl_run || hdr_done) begin
			word_reg <= 64'h0;
			byte_idx_reg <= 3'h0;
		end else if (pay_take) begin
			word_reg <= flush ? 64'h0 : word_merged;
			byte_idx_reg <= flush ? 3'h0 : byte_idx_reg + 3'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			video_valid_o <= 1'b0;
			video_data_o <= 64'h0;
			pixel_count_o <= 4'h0;
			data_type_o <= 6'h00;
			virtual_channel_id_o <= 2'h0;
		end else begin
			video_valid_o <= flush;
			if (flush) begin
				video_data_o <= word_merged;
				pixel_count_o <= {1'b0, byte_idx_reg} + 4'h1;
				data_type_o <= hdr_dt_reg;
				virtual_channel_id_o <= hdr_vc_reg;
			end
		end
	end

	// Sync levels per channel; a disabled channel never shows a sync.
	always_comb begin
		vsync_next = vsync_o & virtual_channel_enables_i;
		hsync_next = hsync_o & virtual_channel_enables_i;
		if (hdr_done && is_short && vc_ok) begin
			case (hdr_dt_reg)
				csr_pkg::DT_FRAME_START: vsync_next[hdr_vc_reg] = 1'b1;
				csr_pkg::DT_FRAME_END: begin
					vsync_next[hdr_vc_reg] = 1'b0;
					hsync_next[hdr_vc_reg] = 1'b0;
				end
				csr_pkg::DT_LINE_START: hsync_next[hdr_vc_reg] = 1'b1;
				csr_pkg::DT_LINE_END: hsync_next[hdr_vc_reg] = 1'b0;
				default: hsync_next = hsync_next;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			vsync_o <= 4'h0;
			hsync_o <= 4'h0;
		end else begin
			vsync_o <= vsync_next;
			hsync_o <= hsync_next;
		end
	end

	// Error sources; a set in the cycle of a clear is kept.
	always_comb begin
		err_set = 18'h0;
		err_set[csr_pkg::ERR_HS_TIMEOUT] = burst_end && state_reg != csr_pkg::ST_HEADER;
		err_set[csr_pkg::ERR_FRAME_SYNC] = hdr_done && is_short && vc_ok
			&& hdr_dt_reg == csr_pkg::DT_FRAME_END && !vsync_o[hdr_vc_reg];
		err_set[csr_pkg::ERR_BAD_VC] = hdr_done && !vc_ok;
		err_set[csr_pkg::ERR_BAD_TYPE] = hdr_done && !is_short && !csr_pkg::dt_known(hdr_dt_reg);
		err_set[csr_pkg::ERR_SOT] = |(lane_sot_err & lane_en);
	end

	always_ff @(posedge clock_i) begin
		if (!ctrl_run) begin
			error_o <= 18'h0;
		end else begin
			error_o <= (error_clear_i ? 18'h0 : error_o) | err_set;
		end
	end

	// A lane pair with both wires low is in ultra-low power.
	always_ff @(posedge clock_i) begin
		if (!phy_run) begin
			clock_lane_sleep_flag_o <= 1'b0;
			data_lane_sleep_flags_o <= 4'h0;
		end else begin
			clock_lane_sleep_flag_o <= !lane_p_s[0] && !lane_n_s[0];
			data_lane_sleep_flags_o <= ~lane_p_s[4:1] & ~lane_n_s[4:1];
		end
	end

	// Events, sticky status cleared by a read, mask and interrupt.
	always_comb begin
		ev_set = 4'h0;
		ev_set[csr_pkg::EV_FRAME_START] = hdr_done && is_short && vc_ok
			&& hdr_dt_reg == csr_pkg::DT_FRAME_START;
		ev_set[csr_pkg::EV_FRAME_END] = hdr_done && is_short && vc_ok
			&& hdr_dt_reg == csr_pkg::DT_FRAME_END;
		ev_set[csr_pkg::EV_ERROR] = |err_set;
		ev_set[csr_pkg::EV_DROP] = hdr_done && !vc_ok;
		status_next = status_reg;
		if (reg_rd_i && reg_addr_i == csr_pkg::REG_STATUS) begin
			status_next = 4'h0;
		end
		status_next = status_next | ev_set;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			status_reg <= csr_pkg::STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			mask_reg <= csr_pkg::MASK_RESET;
		end else if (reg_wr_i && reg_addr_i == csr_pkg::REG_MASK) begin
			mask_reg <= reg_wr_data_i[3:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_reg & mask_reg);
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			reg_rd_data_o <= 32'h0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				csr_pkg::REG_STATUS: reg_rd_data_o <= {28'h0, status_reg};
				csr_pkg::REG_MASK: reg_rd_data_o <= {28'h0, mask_reg};
				csr_pkg::REG_ERROR: reg_rd_data_o <= {14'h0, error_o};
				csr_pkg::REG_LANE_STATE: reg_rd_data_o <= {16'h0, lane_lock, lane_en,
					data_lane_sleep_flags_o, 3'h0, clock_lane_sleep_flag_o};
				default: reg_rd_data_o <= 32'h0;
			endcase
		end else begin
			reg_rd_data_o <= 32'h0;
		end
	end

	chk_phy_reset_hold: assert property (@(posedge clock_i) disable iff (srst_i)
		!phy_run |=> data_lane_sleep_flags_o == 4'h0 && !clock_lane_sleep_flag_o)
		else $error("Lane logic ran while its reset was low.");

	chk_ctrl_reset_hold: assert property (@(posedge clock_i) disable iff (srst_i)
		!ctrl_run |=> !video_valid_o && vsync_o == 4'h0 && error_o == 18'h0)
		else $error("Controller outputs moved while its reset was low.");

	chk_vc_gate_valid: assert property (@(posedge clock_i) disable iff (srst_i)
		pay_take && !virtual_channel_enables_i[hdr_vc_reg] |=> !video_valid_o)
		else $error("Valid raised for a disabled channel.");

	chk_lane_group_size: assert property (@(posedge clock_i) disable iff (srst_i)
		grp_load && lane_sel_reg == csr_pkg::LANES_TWO |=> grp_left_reg == 3'h2 ##1 grp_left_reg == 3'h1)
		else $error("Two-lane select did not deliver two bytes per group.");

	chk_pixel_count: assert property (@(posedge clock_i) disable iff (srst_i)
		video_valid_o |-> pixel_count_o >= 4'h1 && pixel_count_o <= 4'h8)
		else $error("Pixel count out of range while valid.");

	chk_error_clear: assert property (@(posedge clock_i) disable iff (srst_i)
		ctrl_run && error_clear_i && err_set == 18'h0 |=> error_o == 18'h0)
		else $error("Clear did not empty the error register.");

	chk_error_sticky: assert property (@(posedge clock_i) disable iff (srst_i)
		ctrl_run && !error_clear_i ##1 ctrl_run |-> (error_o & $past(error_o)) == $past(error_o))
		else $error("An error bit fell without a clear.");

	chk_sleep_flag: assert property (@(posedge clock_i) disable iff (srst_i)
		phy_run && !lane_p_s[0] && !lane_n_s[0] |=> clock_lane_sleep_flag_o)
		else $error("Clock lane sleep flag missed a low-power state.");

	chk_sync_gate: assert property (@(posedge clock_i) disable iff (srst_i)
		##1 (vsync_o & ~$past(virtual_channel_enables_i)) == 4'h0)
		else $error("Sync raised on a disabled channel.");

	chk_irq_level: assert property (@(posedge clock_i) disable iff (srst_i)
		(|(status_reg & mask_reg)) |=> irq_o)
		else $error("Interrupt missed a pending unmasked event.");

endmodule // csr_fabric_port

`default_nettype wire

//--- verilog/csr_lane_deser.sv
// One data lane deserialiser: hunts the leader byte, then emits bytes least bit first.
// Assumes bit_stb_i marks each link clock edge and bit_i is already synchronised.
`default_nettype none

module csr_lane_deser (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic srst_i,
	// Serial side.
	input wire logic hs_i,
	input wire logic bit_stb_i,
	input wire logic bit_i,
	// Byte side.
	output logic [7:0] byte_o,
	output logic byte_stb_o,
	output logic locked_o,
	output logic sot_err_o
);

	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [2:0] bit_cnt_reg;
	logic [5:0] hunt_cnt_reg;

	assign shift_next = {bit_i, shift_reg[7:1]};

	always_ff @(posedge clock_i) begin
		if (srst_i || !hs_i) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			hunt_cnt_reg <= 6'h00;
			locked_o <= 1'b0;
		end else if (bit_stb_i) begin
			shift_reg <= shift_next;
			if (locked_o) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
			end else if (shift_next == csr_pkg::SOT_SYNC_BYTE) begin
				locked_o <= 1'b1;
				bit_cnt_reg <= 3'h0;
			end else if (hunt_cnt_reg != csr_pkg::SOT_HUNT_LIMIT) begin
				hunt_cnt_reg <= hunt_cnt_reg + 6'h01;
			end
		end
	end

	// A leader that never shows within the hunt limit is reported once per burst.
	always_ff @(posedge clock_i) begin
		if (srst_i || !hs_i) begin
			byte_stb_o <= 1'b0;
			byte_o <= 8'h00;
			sot_err_o <= 1'b0;
		end else begin
			byte_stb_o <= locked_o && bit_stb_i && bit_cnt_reg == 3'h7;
			sot_err_o <= !locked_o && bit_stb_i && shift_next != csr_pkg::SOT_SYNC_BYTE
				&& hunt_cnt_reg == csr_pkg::SOT_HUNT_LIMIT - 6'h01;
			if (locked_o && bit_stb_i && bit_cnt_reg == 3'h7) begin
				byte_o <= shift_next;
			end
		end
	end

	chk_byte_gap: assert property (@(posedge clock_i) disable iff (srst_i)
		byte_stb_o |=> !byte_stb_o)
		else $error("Lane bytes came on two adjacent cycles.");

endmodule // csr_lane_deser

`default_nettype wire

//--- verilog/csr_pkg.sv
// Shared constants, types and helper functions for the camera serial receiver port.
// Assumes every user names items as csr_pkg::name; nothing is imported.
`default_nettype none

package csr_pkg;

	// Lane and word geometry.
	localparam int LANE_COUNT = 4;
	localparam int PIN_COUNT = 5;
	localparam int WORD_BYTES = 8;
	localparam int ERR_WIDTH = 18;
	localparam int EV_WIDTH = 4;

	// Start-of-transmission leader byte and hunt limit in bits.
	localparam logic [7:0] SOT_SYNC_BYTE = 8'hB8;
	localparam logic [5:0] SOT_HUNT_LIMIT = 6'h20;

	// Lane-count select codes.
	localparam logic [1:0] LANES_ONE = 2'h0;
	localparam logic [1:0] LANES_TWO = 2'h1;
	localparam logic [1:0] LANES_FOUR = 2'h3;

	// Short packet data types.
	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END = 6'h01;
	localparam logic [5:0] DT_LINE_START = 6'h02;
	localparam logic [5:0] DT_LINE_END = 6'h03;
	localparam logic [5:0] DT_SHORT_LIMIT = 6'h10;

	// Error bus bit positions.
	localparam int ERR_HS_TIMEOUT = 5;
	localparam int ERR_FRAME_SYNC = 10;
	localparam int ERR_BAD_VC = 12;
	localparam int ERR_BAD_TYPE = 13;
	localparam int ERR_SOT = 16;

	// Event bits of the status and mask registers.
	localparam int EV_FRAME_START = 0;
	localparam int EV_FRAME_END = 1;
	localparam int EV_ERROR = 2;
	localparam int EV_DROP = 3;

	// Register offsets and reset values.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] REG_ERROR = 4'h8;
	localparam logic [3:0] REG_LANE_STATE = 4'hC;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [3:0] STATUS_RESET = 4'h0;

	typedef enum logic [2:0] {
		ST_HEADER, ST_WC_LO, ST_WC_HI, ST_ECC, ST_PAYLOAD, ST_CRC0, ST_CRC1
	} csr_parse_e;

	// Data lanes enabled by a lane-count select code.
	function automatic logic [3:0] lanes_decode(input logic [1:0] sel);
		case (sel)
			LANES_ONE: lanes_decode = 4'h1;
			LANES_TWO: lanes_decode = 4'h3;
			LANES_FOUR: lanes_decode = 4'hF;
			default: lanes_decode = 4'h1;
		endcase
	endfunction

	// Number of data lanes enabled by a lane-count select code.
	function automatic logic [2:0] lane_total(input logic [1:0] sel);
		case (sel)
			LANES_TWO: lane_total = 3'h2;
			LANES_FOUR: lane_total = 3'h4;
			default: lane_total = 3'h1;
		endcase
	endfunction

	// Long packet data types that the receiver knows how to pass on.
	function automatic logic dt_known(input logic [5:0] dt);
		dt_known = (dt >= 6'h18 && dt <= 6'h1F && dt != 6'h1B) || (dt >= 6'h20 && dt <= 6'h24)
			|| (dt >= 6'h28 && dt <= 6'h2D) || (dt >= 6'h30 && dt <= 6'h37);
	endfunction

endpackage

`default_nettype wire

//--- verilog/csr_sync.sv
// Two-stage synchroniser for a group of levels from outside the clock domain.
// Assumes each bit is an independent level; a synchronous reset clears both stages.
`default_nettype none

module csr_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic srst_i,
	// Levels in and out.
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] stage_reg;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			stage_reg <= '0;
			sync_o <= '0;
		end else begin
			stage_reg <= async_i;
			sync_o <= stage_reg;
		end
	end

endmodule // csr_sync

`default_nettype wire
